// File: core/pel_pkg.sv
/*
 * Package for the protection event log: register map, field layouts,
 * reset values, carrier structs and sizing constants.
 * Assumes a 32-bit AXI4-Lite register bus and one 250 MHz clock.
 */
package pel_pkg;

    // ****************************************************************
    // Sizing
    // ****************************************************************
    localparam int unsigned PEL_DEPTH = 2000;
    localparam int unsigned PEL_PW = 11;
    localparam logic [PEL_PW-1:0] PEL_CAP_DEFAULT = 11'h0C8;
    localparam logic [PEL_PW-1:0] PEL_CAP_MIN = 11'h032;
    localparam logic [PEL_PW-1:0] PEL_CAP_MAX = 11'h7D0;
    localparam int unsigned PEL_NSRC = 32;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] PEL_OFS_CTRL = 8'h00;
    localparam logic [7:0] PEL_OFS_CAP = 8'h04;
    localparam logic [7:0] PEL_OFS_MASK = 8'h08;
    localparam logic [7:0] PEL_OFS_COUNT = 8'h0C;
    localparam logic [7:0] PEL_OFS_POP_CODE = 8'h10;
    localparam logic [7:0] PEL_OFS_POP_DATE = 8'h14;
    localparam logic [7:0] PEL_OFS_POP_TIME = 8'h18;
    localparam logic [7:0] PEL_OFS_RR_CODE = 8'h1C;
    localparam logic [7:0] PEL_OFS_RR_DATE = 8'h20;
    localparam logic [7:0] PEL_OFS_RR_TIME = 8'h24;
    localparam logic [7:0] PEL_OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] PEL_OFS_IRQ_EN = 8'h2C;
    localparam logic [7:0] PEL_OFS_IRQ_CLR = 8'h30;

    // ****************************************************************
    // Control fields
    // ****************************************************************
    localparam int unsigned PEL_CTRL_WIPE = 0;
    localparam int unsigned PEL_CTRL_ORDER = 1;
    localparam int unsigned PEL_CTRL_SCALE = 2;
    localparam int unsigned PEL_CTRL_POPUP = 3;
    localparam logic [3:0] PEL_CTRL_RESET = 4'h8;

    // Interrupt status bits.
    localparam int unsigned PEL_IRQ_NEW = 0;
    localparam int unsigned PEL_IRQ_OVR = 1;

    // AXI responses.
    localparam logic [1:0] PEL_RESP_OKAY = 2'h0;
    localparam logic [1:0] PEL_RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [7:0] channel;
        logic [7:0] number;
    } pel_code_s;

    typedef struct packed {
        pel_code_s code;
        logic [15:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
        logic [9:0] milli;
        logic event_overrun_mark;
    } pel_entry_s;

endpackage

// File: core/pel_ram.sv
/*
 * Event storage array with one write port and two registered read ports.
 * Assumes addresses are kept below the depth by the caller.
 */
`timescale 1ns/1ps
module pel_ram
    import pel_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic wr_en_i,
    input wire logic [PEL_PW-1:0] wr_addr_i,
    input wire pel_entry_s wr_data_i,
    input wire logic [PEL_PW-1:0] rda_addr_i,
    output pel_entry_s rda_data_o,
    input wire logic [PEL_PW-1:0] rdb_addr_i,
    output pel_entry_s rdb_data_o
);

    pel_entry_s mem [PEL_DEPTH];

    // Plain synchronous array; no reset so it maps onto block memory.
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rda_data_o <= mem[rda_addr_i];
        rdb_data_o <= mem[rdb_addr_i];
    end

endmodule

// File: core/pel_top.sv
/*
 * Protection event log: stores time stamped event codes in a ring,
 * lets a remote poller drain them, and gives a local panel cursor.
 * Assumes event sources and the time stamp are on sys_clk_i.
 */
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps

module pel_top
    import pel_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [31:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic ev_valid_i,
    input wire pel_code_s ev_code_i,
    input wire pel_entry_s stamp_i,
    input wire logic panel_next_i,
    input wire logic panel_prev_i,
    output pel_entry_s panel_entry_o,
    output logic panel_popup_o,
    output logic fault_value_scale_select_o,
    output logic irq_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [3:0] ctrl_r;
    logic [PEL_PW-1:0] cap_r;
    logic [PEL_NSRC-1:0] mask_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    logic [PEL_PW-1:0] wr_ptr_r;
    logic [PEL_PW-1:0] rd_ptr_r;
    logic [PEL_PW-1:0] count_r;
    logic [PEL_PW-1:0] cur_r;
    logic ovr_pend_r;
    pel_entry_s pop_r;
    pel_entry_s reread_r;
    pel_entry_s ram_a;
    pel_entry_s ram_b;
    pel_entry_s wr_entry;
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic [7:0] ar_addr_r;
    logic rd_wait_r;
    logic pop_fetch_r;

    logic ev_take;
    logic full;
    logic wr_fire;
    logic pop_req;
    logic wipe;

    // Ring index increment and decrement modulo the configured capacity.
    function automatic logic [PEL_PW-1:0] ring_inc(
        input logic [PEL_PW-1:0] p, input logic [PEL_PW-1:0] cap);
        ring_inc = (p == cap - 11'h001) ? 11'h000 : p + 11'h001;
    endfunction

    function automatic logic [PEL_PW-1:0] ring_dec(
        input logic [PEL_PW-1:0] p, input logic [PEL_PW-1:0] cap);
        ring_dec = (p == 11'h000) ? cap - 11'h001 : p - 11'h001;
    endfunction

    // ****************************************************************
    // AXI4-Lite write side
    // ****************************************************************
    assign s_axi_awready_o = !aw_got_r && !s_axi_bvalid_o;
    assign s_axi_wready_o = !w_got_r && !s_axi_bvalid_o;
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid_o;
    assign wipe = wr_fire && aw_addr_r == PEL_OFS_CTRL && wstrb_r[0] &&
        wdata_r[PEL_CTRL_WIPE];

    // Address and data are latched independently, in either order.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= PEL_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_got_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr_i[7:2], 2'b00};
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr_r > PEL_OFS_IRQ_CLR) ?
                    PEL_RESP_SLVERR : PEL_RESP_OKAY;
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    // Settings registers; capacity writes are clamped into range.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= PEL_CTRL_RESET;
            cap_r <= PEL_CAP_DEFAULT;
            mask_r <= '0;
            irq_en_r <= 2'h0;
        end else if (wr_fire) begin
            case (aw_addr_r)
                PEL_OFS_CTRL: begin
                    if (wstrb_r[0]) begin
                        ctrl_r[3:1] <= wdata_r[3:1];
                    end
                end
                PEL_OFS_CAP: begin
                    if (wdata_r[15:0] < {5'h00, PEL_CAP_MIN}) begin
                        cap_r <= PEL_CAP_MIN;
                    end else if (wdata_r[15:0] > {5'h00, PEL_CAP_MAX}) begin
                        cap_r <= PEL_CAP_MAX;
                    end else begin
                        cap_r <= wdata_r[PEL_PW-1:0];
                    end
                end
                PEL_OFS_MASK: mask_r <= wdata_r;
                PEL_OFS_IRQ_EN: irq_en_r <= wdata_r[1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // AXI4-Lite read side
    // ****************************************************************
    assign s_axi_arready_o = !rd_wait_r && !s_axi_rvalid_o;
    // Reading the pop code word consumes an entry; date and time of that
    // entry are then read from the same latched copy.
    assign pop_req = s_axi_arvalid_i && s_axi_arready_o &&
        s_axi_araddr_i[7:0] == PEL_OFS_POP_CODE;

    // Reads wait one cycle, pop code reads on a non-empty ring two, so a pop can fetch from the array first.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_wait_r <= 1'b0;
            ar_addr_r <= 8'h00;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= PEL_RESP_OKAY;
        end else begin
            if (s_axi_arvalid_i && s_axi_arready_o) begin
                rd_wait_r <= 1'b1;
                ar_addr_r <= {s_axi_araddr_i[7:2], 2'b00};
            end else if (rd_wait_r && !pop_fetch_r) begin
                rd_wait_r <= 1'b0;
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= PEL_RESP_OKAY;
                case (ar_addr_r)
                    PEL_OFS_CTRL: s_axi_rdata_o <= {28'h0, ctrl_r};
                    PEL_OFS_CAP: s_axi_rdata_o <= {21'h0, cap_r};
                    PEL_OFS_MASK: s_axi_rdata_o <= mask_r;
                    PEL_OFS_COUNT: s_axi_rdata_o <= {21'h0, count_r};
                    PEL_OFS_POP_CODE: s_axi_rdata_o <=
                        {15'h0, pop_r.event_overrun_mark, pop_r.code};
                    PEL_OFS_POP_DATE: s_axi_rdata_o <=
                        {pop_r.year, pop_r.month, pop_r.day};
                    PEL_OFS_POP_TIME: s_axi_rdata_o <=
                        {5'h0, pop_r.hour, pop_r.minute, pop_r.second,
                         pop_r.milli};
                    PEL_OFS_RR_CODE: s_axi_rdata_o <=
                        {15'h0, reread_r.event_overrun_mark, reread_r.code};
                    PEL_OFS_RR_DATE: s_axi_rdata_o <=
                        {reread_r.year, reread_r.month, reread_r.day};
                    PEL_OFS_RR_TIME: s_axi_rdata_o <=
                        {5'h0, reread_r.hour, reread_r.minute,
                         reread_r.second, reread_r.milli};
                    PEL_OFS_IRQ_STAT: s_axi_rdata_o <= {30'h0, irq_stat_r};
                    PEL_OFS_IRQ_EN: s_axi_rdata_o <= {30'h0, irq_en_r};
                    PEL_OFS_IRQ_CLR: s_axi_rdata_o <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata_o <= 32'h0000_0000;
                        s_axi_rresp_o <= PEL_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Ring pointers
    // ****************************************************************
    assign ev_take = ev_valid_i && !mask_r[ev_code_i.channel[4:0]];
    assign full = count_r == cap_r;

    // New entry: code plus the stamp supplied at the event instant.
    always_comb begin
        wr_entry = stamp_i;
        wr_entry.code = ev_code_i;
        wr_entry.event_overrun_mark = full;
    end

    // A pop on an empty ring returns the last contents with no advance.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            pop_fetch_r <= 1'b0;
        end else if (wipe) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            pop_fetch_r <= 1'b0;
        end else begin
            pop_fetch_r <= pop_req && count_r != '0;
            if (ev_take) begin
                wr_ptr_r <= ring_inc(wr_ptr_r, cap_r);
            end
            if (ev_take && full) begin
                rd_ptr_r <= ring_inc(rd_ptr_r, cap_r);
            end else if (pop_req && count_r != '0) begin
                rd_ptr_r <= ring_inc(rd_ptr_r, cap_r);
            end
            if (ev_take && !full && !(pop_req && count_r != '0)) begin
                count_r <= count_r + 11'h001;
            end else if (!ev_take && pop_req && count_r != '0) begin
                count_r <= count_r - 11'h001;
            end
        end
    end

    // Popped entry is latched, and becomes the reread copy too.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pop_r <= '0;
            reread_r <= '0;
        end else if (pop_fetch_r) begin
            pop_r <= ram_a;
            reread_r <= ram_a;
        end
    end

    // ****************************************************************
    // Panel cursor and popup
    // ****************************************************************
    // The cursor jumps to the newest entry on popup or overrun and to zero on a wipe, otherwise it
    // only moves by panel steps; direction flips with the order setting.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_r <= '0;
            ovr_pend_r <= 1'b0;
        end else if (wipe) begin
            cur_r <= '0;
            ovr_pend_r <= 1'b0;
        end else if (ev_take && (ctrl_r[PEL_CTRL_POPUP] || full)) begin
            cur_r <= wr_ptr_r;
            ovr_pend_r <= full;
        end else if (panel_next_i != panel_prev_i) begin
            if (panel_next_i ^ ctrl_r[PEL_CTRL_ORDER]) begin
                cur_r <= ring_inc(cur_r, cap_r);
            end else begin
                cur_r <= ring_dec(cur_r, cap_r);
            end
            ovr_pend_r <= 1'b0;
        end
    end

    assign panel_entry_o = ram_b;
    // Overrun forces the popup so the newest entry is seen.
    assign panel_popup_o = ctrl_r[PEL_CTRL_POPUP] || ovr_pend_r;
    assign fault_value_scale_select_o = ctrl_r[PEL_CTRL_SCALE];

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    // New event and overrun are sticky; a simultaneous set beats clear.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_stat_r <= 2'h0;
        end else begin
            irq_stat_r <= (irq_stat_r &
                ~((wr_fire && aw_addr_r == PEL_OFS_IRQ_CLR) ?
                  wdata_r[1:0] : 2'h0)) |
                {ev_take && full, ev_take};
        end
    end

    assign irq_o = |(irq_stat_r & irq_en_r);

    pel_ram u_ram (
        .sys_clk_i(sys_clk_i),
        .wr_en_i(ev_take && !wipe),
        .wr_addr_i(wr_ptr_r),
        .wr_data_i(wr_entry),
        .rda_addr_i(rd_ptr_r),
        .rda_data_o(ram_a),
        .rdb_addr_i(cur_r),
        .rdb_data_o(ram_b)
    );

endmodule

// File: testbench/pel_scada_model.sv
/* Remote poller model: single register writes and reads on the bus,
   answering promptly or slowly. Assumes the block's clock. */
`timescale 1ns/1ps
module pel_scada_model (
    input wire logic clk_i,
    output logic [31:0] awaddr_o,
    output logic awvalid_o,
    input wire logic awready_i,
    output logic [31:0] wdata_o,
    output logic wvalid_o,
    input wire logic wready_i,
    input wire logic bvalid_i,
    input wire logic [1:0] bresp_i,
    output logic bready_o,
    output logic [31:0] araddr_o,
    output logic arvalid_o,
    input wire logic arready_i,
    input wire logic rvalid_i,
    input wire logic [31:0] rdata_i,
    input wire logic [1:0] rresp_i,
    output logic rready_o
);
    bit slow = 1'b0;

    // Idle at time zero.
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end

    // Released lines show the inverse so a stale value never passes.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk_i);
        awaddr_o <= {24'h0, a};
        wdata_o <= d;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= !slow;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk_i);
            if (!aw_ok && awready_i) begin
                aw_ok = 1'b1;
                awvalid_o <= 1'b0;
                awaddr_o <= ~awaddr_o;
            end
            if (!w_ok && wready_i) begin
                w_ok = 1'b1;
                wvalid_o <= 1'b0;
                wdata_o <= ~wdata_o;
            end
        end
        if (slow) begin
            repeat (4) @(posedge clk_i);
            bready_o <= 1'b1;
            @(posedge clk_i);
        end
        while (!bvalid_i) @(posedge clk_i);
        resp = bresp_i;
        bready_o <= 1'b0;
    endtask

    // Each read of the pop word takes one entry; no retry is made here.
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge clk_i);
        araddr_o <= {24'h0, a};
        arvalid_o <= 1'b1;
        rready_o <= !slow;
        do @(posedge clk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        araddr_o <= ~araddr_o;
        if (slow) begin
            repeat (4) @(posedge clk_i);
            rready_o <= 1'b1;
            @(posedge clk_i);
        end
        while (!rvalid_i) @(posedge clk_i);
        d = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
    endtask
endmodule

// File: testbench/pel_top_properties.sv
/* Checker for pel_top: bus answer timing, holding and refusal, and
   the ranges of the capacity and count words. Assumes one clock. */
`timescale 1ns/1ps
module pel_top_properties
    import pel_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [31:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic panel_popup_o
);
    // ****
    // Helpers
    // ****
    logic [7:0] ofs_r;
    wire logic wr_take = s_axi_awvalid_i && s_axi_awready_o
        && s_axi_wvalid_i && s_axi_wready_o;
    wire logic rd_take = s_axi_arvalid_i && s_axi_arready_o;
    wire logic rv = s_axi_rvalid_o;

    // Offset of the read in flight; only one read is ever pending.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ofs_r <= 8'h00;
        end else if (rd_take) begin
            ofs_r <= s_axi_araddr_i[7:0];
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_wr_answer_time: assert property (
        wr_take |-> ##2 s_axi_bvalid_o)
        else $error("Write answer not two cycles after request.");
    a_rd_answer_time: assert property (
        rd_take |-> ##[2:3] rv)
        else $error("Read answer outside two to three cycles.");
    a_wr_answer_hold: assert property (
        s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o))
        else $error("Write answer dropped before taken.");
    a_rd_answer_hold: assert property (
        rv && !s_axi_rready_i |=> rv && $stable(s_axi_rdata_o))
        else $error("Read answer dropped or changed before taken.");
    a_busy_refuse: assert property (
        (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        and (rv |-> !s_axi_arready_o))
        else $error("Request taken while an answer is pending.");
    a_bad_offset: assert property (
        rv && ofs_r > PEL_OFS_IRQ_CLR |->
        s_axi_rresp_o == PEL_RESP_SLVERR && s_axi_rdata_o == 32'h0)
        else $error("Unmapped read not refused with zero data.");
    a_cap_bounds: assert property (
        rv && ofs_r == PEL_OFS_CAP |-> s_axi_rdata_o[31:11] == 21'h0
        && s_axi_rdata_o[10:0] inside {[PEL_CAP_MIN:PEL_CAP_MAX]})
        else $error("Capacity outside its range.");
    a_count_bound: assert property (
        rv && ofs_r == PEL_OFS_COUNT |->
        s_axi_rdata_o <= {21'h0, PEL_CAP_MAX})
        else $error("Count above the largest capacity.");
    a_popup_reset: assert property (
        $rose(rst_b_i) |-> panel_popup_o)
        else $error("Popup not on after reset.");

    c_pop: cover property (rv && ofs_r == PEL_OFS_POP_CODE);
    c_refused: cover property (rv && s_axi_rresp_o == PEL_RESP_SLVERR);
    c_slow_write: cover property (s_axi_bvalid_o && !s_axi_bready_i);
endmodule

bind pel_top pel_top_properties u_props (.sys_clk_i, .rst_b_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .panel_popup_o);

// File: testbench/test_protection_event_log.sv
/* Bench for the event log: settings, masking, polling, reread, wipe,
   overrun and the interrupt. Assumes the poller model and checker. */
`timescale 1ns/1ps
module test_protection_event_log
    import pel_pkg::*;
;
    localparam logic [31:0] TW = {5'h0, 5'h08, 6'h23, 6'h0D, 10'h19D};
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i;
    logic [31:0] s_axi_rdata_o, rd_data;
    logic [3:0] s_axi_wstrb_i = 4'hF;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i;
    logic s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
    logic s_axi_rready_i, panel_popup_o, fault_value_scale_select_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic ev_valid_i = 1'b0;
    logic irq_o;
    pel_entry_s panel_entry_o;
    logic panel_next_i = 1'b0;
    logic panel_prev_i = 1'b0;
    pel_code_s ev_code_i = 16'h0;
    pel_entry_s stamp_i = {16'h0, 16'h07E8, 8'h01, 8'h00, TW[26:0], 1'b0};
    logic [31:0] cap_in [3] = '{32'h10, 32'h7FF, 32'h32};
    logic [31:0] cap_ex [3] = '{32'h32, 32'h7D0, 32'h32};
    int n_fail = 0;
    int cmp_count = 0;

    // A 4 ns clock.
    always #2 sys_clk_i = ~sys_clk_i;

    pel_top dut (.sys_clk_i, .rst_b_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .ev_valid_i,
        .ev_code_i, .stamp_i, .panel_next_i, .panel_prev_i,
        .panel_entry_o, .panel_popup_o, .fault_value_scale_select_o,
        .irq_o);

    pel_scada_model poller (.clk_i(sys_clk_i), .awaddr_o(s_axi_awaddr_i),
        .awvalid_o(s_axi_awvalid_i), .awready_i(s_axi_awready_o),
        .wdata_o(s_axi_wdata_i), .wvalid_o(s_axi_wvalid_i),
        .wready_i(s_axi_wready_o), .bvalid_i(s_axi_bvalid_o),
        .bresp_i(s_axi_bresp_o), .bready_o(s_axi_bready_i),
        .araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i),
        .arready_i(s_axi_arready_o), .rvalid_i(s_axi_rvalid_o),
        .rdata_i(s_axi_rdata_o), .rresp_i(s_axi_rresp_o),
        .rready_o(s_axi_rready_i));

    // ****
    // Tasks
    // ****
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        logic [31:0] d;
        logic [1:0] r;
        poller.rd(a, d, r);
        chk(what, d, exp);
    endtask

    // One event pulse; the stamp's day carries the number to tell apart.
    task automatic ev(input logic [7:0] ch, input logic [7:0] n);
        @(posedge sys_clk_i);
        ev_valid_i <= 1'b1;
        ev_code_i <= {ch, n};
        stamp_i.day <= n;
        @(posedge sys_clk_i);
        ev_valid_i <= 1'b0;
    endtask

    task automatic pop(input logic [7:0] ch, input logic [7:0] n,
                       input logic mk);
        rc(PEL_OFS_POP_CODE, {15'h0, mk, ch, n}, "pop code");
        rc(PEL_OFS_POP_DATE, {16'h07E8, 8'h01, n}, "pop date");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // The whole sequence needs a few thousand cycles at most.
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        $display("CHECK FAILED watchdog exp end seen hang");
        report_and_stop();
    end

    // ****
    // Tests
    // ****
    initial begin
        repeat (5) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        rc(PEL_OFS_CAP, 32'hC8, "cap reset");
        rc(PEL_OFS_CTRL, 32'h8, "ctrl reset");
        rc(PEL_OFS_COUNT, 32'h0, "count reset");
        chk("popup", {31'h0, panel_popup_o}, 32'h1);
        poller.rd(8'h34, rd_data, resp);
        chk("bad resp", {30'h0, resp}, {30'h0, PEL_RESP_SLVERR});
        poller.slow = 1'b1;
        poller.wr(PEL_OFS_CTRL, 32'h6, resp);
        rc(PEL_OFS_CTRL, 32'h6, "ctrl");
        poller.slow = 1'b0;
        chk("scale", {31'h0, fault_value_scale_select_o}, 32'h1);
        chk("popup off", {31'h0, panel_popup_o}, 32'h0);
        foreach (cap_in[i]) begin
            poller.wr(PEL_OFS_CAP, cap_in[i], resp);
            rc(PEL_OFS_CAP, cap_ex[i], "cap clamp");
        end
        poller.wr(PEL_OFS_MASK, 32'h8, resp);
        poller.wr(PEL_OFS_IRQ_EN, 32'h3, resp);
        ev(8'h03, 8'h01);
        rc(PEL_OFS_COUNT, 32'h0, "masked count");
        chk("irq idle", {31'h0, irq_o}, 32'h0);
        ev(8'h1E, 8'h02);
        ev(8'h05, 8'h07);
        rc(PEL_OFS_COUNT, 32'h2, "count");
        chk("irq set", {31'h0, irq_o}, 32'h1);
        rc(PEL_OFS_IRQ_STAT, 32'h1, "stat new");
        poller.wr(PEL_OFS_IRQ_CLR, 32'h1, resp);
        rc(PEL_OFS_IRQ_STAT, 32'h0, "stat clear");
        chk("irq clear", {31'h0, irq_o}, 32'h0);
        pop(8'h1E, 8'h02, 1'b0);
        repeat (2) rc(PEL_OFS_RR_CODE, 32'h1E02, "reread");
        rc(PEL_OFS_RR_TIME, TW, "reread time");
        pop(8'h05, 8'h07, 1'b0);
        poller.wr(PEL_OFS_CTRL, 32'h1, resp);
        rc(PEL_OFS_COUNT, 32'h0, "wiped");
        poller.wr(PEL_OFS_IRQ_CLR, 32'h3, resp);
        for (int i = 0; i <= 50; i++) begin
            ev(8'h11, i[7:0]);
        end
        rc(PEL_OFS_COUNT, 32'h32, "full count");
        rc(PEL_OFS_IRQ_STAT, 32'h3, "stat overrun");
        panel_next_i <= 1'b1;
        @(posedge sys_clk_i) panel_next_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        chk("step", panel_entry_o[75:44], 32'h110107E8);
        for (int i = 1; i <= 50; i++) begin
            pop(8'h11, i[7:0], i == 50);
        end
        report_and_stop();
    end
endmodule
